//--- fsw_pkg.sv
/*
 * fsw_pkg: constants, register map and carrier types of the fail-safe
 * watchdog units (software watchdog and clock fail monitor).
 * Assumes a 200 MHz sys_clk; all timing counts except OSC_WIN_CYC are derived from CLK_NS.
 */
package fsw_pkg;
    localparam int CLK_NS        = 5;
    // software watchdog: 256 ticks give the shortest period
    localparam int WDT_MIN_US    = 512;
    localparam int WDT_MAX_MS    = 1100;
    localparam int WDT_TICK_NS   = WDT_MIN_US * 1000 / 256;
    localparam int WDT_TICK_CYC  = WDT_TICK_NS / CLK_NS;
    localparam int WDT_SLOW_DIV  = 16;
    localparam int WDT_RST_NS    = 120;
    localparam int WDT_RST_CYC   = (WDT_RST_NS + CLK_NS - 1) / CLK_NS;
    // clock fail monitor
    localparam int OSC_STAB_NS   = 250000;
    localparam int OSC_STAB_CYC  = OSC_STAB_NS / CLK_NS;
    localparam int OSC_WIN_CYC   = 256;
    localparam int RST_TYP_NS    = 18000;
    localparam int RST_MAX_NS    = 34000;
    localparam int RST_MAX_CYC   = RST_MAX_NS / CLK_NS;

    // register byte offsets
    localparam logic [7:0] OFF_IEN_A = 8'h00;
    localparam logic [7:0] OFF_IEN_B = 8'h04;
    localparam logic [7:0] OFF_PRIO  = 8'h08;
    localparam logic [7:0] OFF_REL   = 8'h0c;
    localparam logic [7:0] OFF_STAT  = 8'h10;
    localparam logic [7:0] OFF_MASK  = 8'h14;
    localparam logic [7:0] OFF_MON   = 8'h18;
    localparam logic [7:0] OFF_CNT   = 8'h1c;

    // field positions
    localparam int ARM_BIT   = 0;
    localparam int START_BIT = 0;
    localparam int FLAG_BIT  = 0;
    localparam int SLOW_BIT  = 7;
    localparam int IRQ_WDT   = 0;
    localparam int IRQ_FAIL  = 1;
    localparam int IRQ_OK    = 2;
    localparam int IRQ_W     = 3;

    // reset values
    localparam logic [7:0]       REL_RST  = 8'h00;
    localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } fsw_bus_t;

    typedef enum logic [1:0] {
        OSC_FAIL = 2'b00,
        OSC_STAB = 2'b01,
        OSC_OK   = 2'b10,
        OSC_PD   = 2'b11
    } fsw_osc_t;

    // initial count of the software watchdog from its reload byte
    function automatic logic [14:0] fsw_load(input logic [6:0] rel);
        return {rel, 8'h00};
    endfunction
endpackage

//--- fsw_edge_cnt.sv
/*
 * fsw_edge_cnt: synchronises a free clock signal from a pin and counts its
 * rising edges over a window closed by clear.
 * Assumes the pin toggles well below half the sys_clk rate.
 */
`timescale 1ns/1ps
module fsw_edge_cnt #(
    parameter int W = 9
) (
    input  wire logic         sys_clk, // system clock
    input  wire logic         rstn,    // sync reset, active low
    input  wire logic         ce,      // clock enable
    input  wire logic         clear,   // start a new window
    input  wire logic         pin,     // raw clock from a pin
    output logic      [W-1:0] count    // edges in the current window
);
    logic s1;
    logic s2;
    logic s3;
    wire  rise = s2 && !s3;
    wire  full = &count;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // saturate so a runaway clock still reads as the faster one
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            count <= '0;
        end else if (ce) begin
            if (clear) begin
                count <= W'(rise);
            end else if (rise && !full) begin
                count <= count + 1'b1;
            end
        end
    end
endmodule

//--- fsw_watchdog.sv
/*
 * fsw_watchdog: software watchdog and clock fail monitor with a small
 * register port and one level interrupt.
 * Assumes a single-cycle register master on sys_clk and raw oscillator,
 * start and power-down levels arriving from pins.
 */
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Operation
// - watchdog period 512 us to about 1.1 s
// - start pin high in reset starts watchdog
// - start pin sampled only during reset
// - writing start bit starts idle watchdog
// - refresh needs arm write then start write
// - timeout resets chip, counts on, sets flag
// - software write clears the timeout flag
// - reference faster than main oscillator means failure
// - on failure use reference clock, hold reset
// - on recovery extend reset 0.25 ms, release
// - power-down exit supervised like a failure
// - after power-on reset clocked from reference
// - reset state reached within 34 us
module fsw_watchdog #(
    parameter int STAB_CYC = fsw_pkg::OSC_STAB_CYC, // stabilising reset
    parameter int TICK_CYC = fsw_pkg::WDT_TICK_CYC, // cycles per tick
    parameter int WIN_CYC  = fsw_pkg::OSC_WIN_CYC,  // compare window
    parameter int CNT_W    = 9                      // edge count width
) (
    input  wire logic              sys_clk,    // system clock
    input  wire logic              rstn,       // sync reset, active low
    input  wire logic              ce,         // clock enable
    input  wire fsw_pkg::fsw_bus_t bus,        // register request
    output logic            [31:0] rdata,      // read data, next cycle
    input  wire logic              hwStartPin, // watchdog start strap
    input  wire logic              pdPin,      // hard power-down pin
    input  wire logic              mainOscPin, // main oscillator
    input  wire logic              rcOscPin,   // reference oscillator
    output logic                   irq,        // interrupt level
    output logic                   chipReset,  // chip reset, high active
    output logic                   clkSelRc    // chip clock from reference
);
    import fsw_pkg::*;

    localparam int PW = $clog2(TICK_CYC);
    localparam int SW = $clog2(STAB_CYC + 1);
    localparam int WW = $clog2(WIN_CYC);
    localparam logic [3:0] SLOW_END = 4'(WDT_SLOW_DIV - 1);

    // pin synchronisers
    logic hwS1;
    logic hwS2;
    logic pdS1;
    logic pdS2;

    always_ff @(posedge sys_clk) begin
        if (ce || !rstn) begin
            hwS1 <= hwStartPin;
            hwS2 <= hwS1;
            pdS1 <= pdPin;
            pdS2 <= pdS1;
        end
    end

    // register decode
    wire wrArm   = bus.wr && bus.addr == OFF_IEN_A;
    wire wrStart = bus.wr && bus.addr == OFF_IEN_B;
    wire wrPrio  = bus.wr && bus.addr == OFF_PRIO;
    wire wrRel   = bus.wr && bus.addr == OFF_REL;
    wire wrMask  = bus.wr && bus.addr == OFF_MASK;
    wire rdStat  = bus.rd && bus.addr == OFF_STAT;

    logic [7:0]       rel;
    logic [IRQ_W-1:0] mask;
    logic             armed;
    logic             running;
    logic             toFlag;
    logic [14:0]      wdtCount;
    logic [PW-1:0]    preCnt;
    logic [3:0]       slowCnt;
    logic [4:0]       wdtRstCnt;

    // software watchdog timing
    wire preEnd  = preCnt == PW'(TICK_CYC - 1);
    wire slowEnd = slowCnt == SLOW_END;
    wire tick    = ce && running && preEnd
                   && (!rel[SLOW_BIT] || slowEnd);
    wire timeout = tick && (&wdtCount);
    wire startBit = wrStart && bus.wdata[START_BIT];
    wire startSw  = ce && startBit && !running;
    wire refresh  = ce && startBit && running && armed;
    wire [14:0] initCnt = fsw_load(rel[6:0]);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            preCnt  <= '0;
            slowCnt <= 4'h0;
        end else if (ce) begin
            if (!running || preEnd) begin
                preCnt <= '0;
            end else begin
                preCnt <= preCnt + 1'b1;
            end
            if (!running) begin
                slowCnt <= 4'h0;
            end else if (preEnd) begin
                slowCnt <= slowCnt + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rel  <= REL_RST;
            mask <= MASK_RST;
        end else if (ce) begin
            if (wrRel) begin
                rel <= bus.wdata[7:0];
            end
            if (wrMask) begin
                mask <= bus.wdata[IRQ_W-1:0];
            end
        end
    end

    // strap caught only while rstn holds; later pin moves do nothing
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            running <= hwS2;
        end else if (startSw) begin
            running <= 1'b1;
        end
    end

    // the arm bit survives only until the very next register write
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            armed <= 1'b0;
        end else if (ce && bus.wr) begin
            armed <= wrArm && bus.wdata[ARM_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wdtCount <= 15'h0000;
        end else if (startSw || refresh) begin
            wdtCount <= initCnt;
        end else if (timeout) begin
            wdtCount <= initCnt;
        end else if (tick) begin
            wdtCount <= wdtCount + 15'h0001;
        end
    end

    // timeout flag: set wins over a clearing write
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            toFlag <= 1'b0;
        end else if (timeout) begin
            toFlag <= 1'b1;
        end else if (ce && wrPrio && !bus.wdata[FLAG_BIT]) begin
            toFlag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wdtRstCnt <= 5'h00;
        end else if (timeout) begin
            wdtRstCnt <= 5'(WDT_RST_CYC);
        end else if (ce && wdtRstCnt != 5'h00) begin
            wdtRstCnt <= wdtRstCnt - 5'h01;
        end
    end

    // clock fail monitor: edge counts over a fixed window
    logic [WW-1:0]    winCnt;
    logic [CNT_W-1:0] mainCnt;
    logic [CNT_W-1:0] rcCnt;
    logic [SW-1:0]    stabCnt;
    fsw_osc_t         oscState;
    fsw_osc_t         next_oscState;

    wire winEnd   = ce && winCnt == WW'(WIN_CYC - 1);
    wire failSeen = rcCnt > mainCnt;
    wire okSeen   = mainCnt > rcCnt;
    wire stabDone = stabCnt == SW'(STAB_CYC - 1);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            winCnt <= '0;
        end else if (ce) begin
            winCnt <= winEnd ? '0 : winCnt + 1'b1;
        end
    end

    fsw_edge_cnt #(
        .W       (CNT_W)
    ) u_mainCnt (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .clear   (winEnd),
        .pin     (mainOscPin),
        .count   (mainCnt)
    );

    fsw_edge_cnt #(
        .W       (CNT_W)
    ) u_rcCnt (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .clear   (winEnd),
        .pin     (rcOscPin),
        .count   (rcCnt)
    );

    always_comb begin
        next_oscState = oscState;
        if (pdS2) begin
            next_oscState = OSC_PD;
        end else begin
            case (oscState)
                OSC_PD: begin
                    next_oscState = OSC_FAIL;
                end
                OSC_FAIL: begin
                    if (winEnd && okSeen) begin
                        next_oscState = OSC_STAB;
                    end
                end
                OSC_STAB: begin
                    if (winEnd && failSeen) begin
                        next_oscState = OSC_FAIL;
                    end else if (stabDone) begin
                        next_oscState = OSC_OK;
                    end
                end
                OSC_OK: begin
                    if (winEnd && failSeen) begin
                        next_oscState = OSC_FAIL;
                    end
                end
                default: begin
                    next_oscState = OSC_FAIL;
                end
            endcase
        end
    end

    // reset enters the failure state so the reference clocks reset early
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            oscState <= OSC_FAIL;
        end else if (ce) begin
            oscState <= next_oscState;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn || oscState != OSC_STAB) begin
            stabCnt <= '0;
        end else if (ce) begin
            stabCnt <= stabCnt + 1'b1;
        end
    end

    // interrupt status, cleared by reading it; new events win
    logic [IRQ_W-1:0] status;
    wire  [IRQ_W-1:0] events;
    wire  [IRQ_W-1:0] next_status;
    wire  oscHold  = next_oscState != OSC_OK;
    wire  nextRst  = oscHold || timeout || wdtRstCnt > 5'h01;

    assign events[IRQ_WDT]  = timeout;
    assign events[IRQ_FAIL] = ce && next_oscState == OSC_FAIL
                              && (oscState == OSC_OK || oscState == OSC_STAB);
    assign events[IRQ_OK]   = ce && next_oscState == OSC_OK
                              && oscState != OSC_OK;
    assign next_status = (rdStat ? '0 : status) | events;

    wire [31:0] rdMux =
        bus.addr == OFF_IEN_A ? {31'h0, armed} :
        bus.addr == OFF_IEN_B ? {31'h0, running} :
        bus.addr == OFF_PRIO  ? {31'h0, toFlag} :
        bus.addr == OFF_REL   ? {24'h0, rel} :
        bus.addr == OFF_STAT  ? {29'h0, status} :
        bus.addr == OFF_MASK  ? {29'h0, mask} :
        bus.addr == OFF_MON   ? {28'h0, oscState, clkSelRc, chipReset} :
        bus.addr == OFF_CNT   ? {17'h0, wdtCount} : 32'h0;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            status <= '0;
            irq    <= 1'b0;
            rdata  <= 32'h0;
        end else if (ce) begin
            status <= next_status;
            irq    <= |(next_status & mask);
            rdata  <= bus.rd ? rdMux : 32'h0;
        end
    end

    // reset and clock selection are both driven from the next state so
    // they line up with oscState; rstn itself forces both at once
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            chipReset <= 1'b1;
            clkSelRc  <= 1'b1;
        end else if (ce) begin
            chipReset <= nextRst;
            clkSelRc  <= next_oscState == OSC_FAIL;
        end
    end

    strap_only_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !running && !startSw |=> !running)
        else $error("watchdog started without strap or start write");

    refresh_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wrStart && bus.wdata[START_BIT] && running && !armed && ce && !tick
        |=> wdtCount == $past(wdtCount))
        else $error("count reloaded without arm write");

    timeout_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        timeout |=> toFlag && chipReset && running && wdtCount == $past(initCnt))
        else $error("timeout did not reset, flag and reload");

    wdt_rst_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        timeout && ce ##1 ce[*7] |-> chipReset)
        else $error("watchdog reset too short");

    flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && wrPrio && !bus.wdata[FLAG_BIT] && !timeout |=> !toFlag)
        else $error("timeout flag not cleared by write");

    fail_detect_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        winEnd && failSeen && !pdS2 && oscState != OSC_PD
        |=> oscState == OSC_FAIL)
        else $error("failure not declared");

    fail_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        oscState == OSC_FAIL |-> clkSelRc && chipReset)
        else $error("failure without reference clock and reset");

    stab_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        oscState == OSC_STAB ##1 oscState == OSC_OK
        |-> $past(stabCnt) == SW'(STAB_CYC - 1)
            && chipReset == ($past(timeout) || $past(wdtRstCnt) > 5'h01))
        else $error("stabilising reset length wrong");

    pd_exit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && oscState == OSC_PD && !pdS2 |=> oscState == OSC_FAIL)
        else $error("power-down exit not supervised");

    poweron_a: assert property (@(posedge sys_clk)
        !rstn |=> chipReset && clkSelRc && oscState == OSC_FAIL)
        else $error("reset state not reached after power-on");
endmodule

//--- fsw_watchdog_tb_top.sv
/*
 * fsw_watchdog_tb_top: self-checking bench for the fail-safe watchdog units.
 * Assumes fsw_pkg and fsw_watchdog are compiled first; counts are shortened.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module fsw_watchdog_tb_top;
    import fsw_pkg::*;
    localparam int STAB = 20;
    localparam int TICK = 4;
    localparam int WIN  = 16;

    logic        sys_clk;
    logic        rstn;
    logic        ce;
    fsw_bus_t    bus;
    logic [31:0] rdata;
    logic        hwStartPin;
    logic        pdPin;
    logic        mainOscPin;
    logic        rcOscPin;
    logic        irq;
    logic        chipReset;
    logic        clkSelRc;
    int          error_cnt;
    int          samples_checked;
    int          cyc;
    int          mainHalf;
    int          rcHalf;
    int          mc;
    int          rc;
    int          per;
    int          t0;
    int          n;
    logic [6:0]  rel;
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];
    logic        rdPend;

    fsw_watchdog #(.STAB_CYC(STAB), .TICK_CYC(TICK), .WIN_CYC(WIN), .CNT_W(9)) fsw_watchdog_i (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .ce         (ce),
        .bus        (bus),
        .rdata      (rdata),
        .hwStartPin (hwStartPin),
        .pdPin      (pdPin),
        .mainOscPin (mainOscPin),
        .rcOscPin   (rcOscPin),
        .irq        (irq),
        .chipReset  (chipReset),
        .clkSelRc   (clkSelRc)
    );

    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            results();
        end
    end

    // main half period 0 stops the main oscillator at its last level
    always @(posedge sys_clk) begin
        if (mainHalf != 0) begin
            if (mc >= mainHalf - 1) begin
                mc         <= 0;
                mainOscPin <= ~mainOscPin;
            end else begin
                mc <= mc + 1;
            end
        end
        if (rc >= rcHalf - 1) begin
            rc       <= 0;
            rcOscPin <= ~rcOscPin;
        end else begin
            rc <= rc + 1;
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rdPend) begin
            `CHK(rdata & mskQ[0], expQ[0] & mskQ[0])
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
        rdPend <= bus.rd & rstn;
    end

    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        op(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(e);
        mskQ.push_back(m);
        op(1'b0, 1'b1, a, 32'h0);
    endtask

    task automatic waitSig(input int sel, input logic v, output int k);
        k = 0;
        while (((sel != 0) ? clkSelRc : chipReset) !== v && k < 10000) begin
            @(negedge sys_clk);
            k++;
        end
        `CHK(k < 10000, 1'b1)
    endtask

    task automatic recover();
        int k;
        waitSig(1, 1'b0, k);
        waitSig(0, 1'b0, k);
        `CHK(k inside {[STAB-2:STAB+3]}, 1'b1)
        rd(OFF_MON, 32'h8, 32'hf);
    endtask

    task automatic resetDut(input logic strap);
        hwStartPin <= strap;
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(negedge sys_clk);
        `CHK(chipReset, 1'b1)
        `CHK(clkSelRc, 1'b1)
    endtask

    task results();
        $display("checked %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        void'($urandom(90));
        bus = '0;
        ce = 1'b1;
        rstn = 1'b0;
        hwStartPin = 1'b0;
        pdPin = 1'b0;
        mainOscPin = 1'b0;
        rcOscPin = 1'b0;
        mainHalf = 0;
        rcHalf = 8;
        mc = 0;
        rc = 0;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        rdPend = 1'b0;
        rel = 7'h7c + 7'($urandom % 4);
        per = (32768 - int'(rel) * 256) * TICK;
        resetDut(1'b0);
        rd(OFF_MON, 32'h3, 32'hf);
        mainHalf <= 3 + int'($urandom % 2);
        recover();
        wr(OFF_MASK, 32'h4);
        repeat (2) @(negedge sys_clk);
        `CHK(irq, 1'b1)
        rd(OFF_STAT, 32'h4, 32'h7);
        rd(OFF_STAT, 32'h0, 32'h7);
        @(negedge sys_clk);
        `CHK(irq, 1'b0)
        wr(OFF_MASK, 32'h0);
        rd(8'h20, 32'h0, 32'hffffffff);
        wr(8'h24, 32'hff);
        rd(OFF_MASK, 32'h0, 32'hffffffff);
        wr(OFF_REL, {25'h0, rel});
        rd(OFF_REL, {25'h0, rel}, 32'hff);
        // a strap change in normal running must not start the watchdog
        hwStartPin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(OFF_IEN_B, 32'h0, 32'h1);
        hwStartPin <= 1'b0;
        mainHalf <= 0;
        waitSig(1, 1'b1, n);
        `CHK(n <= 3 * WIN, 1'b1)
        `CHK(chipReset, 1'b1)
        rd(OFF_STAT, 32'h2, 32'h2);
        mainHalf <= 3;
        recover();
        pdPin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(OFF_MON, 32'hd, 32'hf);
        pdPin <= 1'b0;
        waitSig(1, 1'b1, n);
        recover();
        wr(OFF_IEN_B, 32'h1);
        t0 = cyc;
        rd(OFF_IEN_B, 32'h1, 32'h1);
        // arm cancelled by another write: no refresh
        repeat (per / 2) @(posedge sys_clk);
        wr(OFF_IEN_A, 32'h1);
        wr(OFF_MASK, 32'h0);
        wr(OFF_IEN_B, 32'h1);
        waitSig(0, 1'b1, n);
        `CHK((cyc - t0) inside {[per-8:per+8]}, 1'b1)
        waitSig(0, 1'b0, n);
        `CHK(n inside {[WDT_RST_CYC-1:WDT_RST_CYC+1]}, 1'b1)
        rd(OFF_IEN_B, 32'h1, 32'h1);
        rd(OFF_PRIO, 32'h1, 32'h1);
        rd(OFF_STAT, 32'h1, 32'h1);
        repeat (per / 2) @(posedge sys_clk);
        wr(OFF_IEN_A, 32'h1);
        rd(OFF_IEN_A, 32'h1, 32'h1);
        wr(OFF_IEN_B, 32'h1);
        t0 = cyc;
        waitSig(0, 1'b1, n);
        `CHK((cyc - t0) inside {[per-8:per+8]}, 1'b1)
        t0 = cyc;
        waitSig(0, 1'b0, n);
        waitSig(0, 1'b1, n);
        `CHK((cyc - t0) inside {[per-8:per+8]}, 1'b1)
        wr(OFF_PRIO, 32'h0);
        rd(OFF_PRIO, 32'h0, 32'h1);
        resetDut(1'b1);
        rd(OFF_IEN_B, 32'h1, 32'h1);
        repeat (4) @(posedge sys_clk);
        // slow prescale after a refresh to 0, then a frozen stretch:
        // at most one slow tick fits before the read, fast mode gives six
        wr(OFF_REL, 32'h80);
        wr(OFF_IEN_A, 32'h1);
        wr(OFF_IEN_B, 32'h1);
        ce <= 1'b0;
        repeat (100) @(posedge sys_clk);
        ce <= 1'b1;
        repeat (24) @(posedge sys_clk);
        rd(OFF_CNT, 32'h0, 32'h7ffe);
        repeat (4) @(posedge sys_clk);
        results();
    end
endmodule
